// File: rtl/iss_source_select.sv
// source select device: two select registers feeding pwm fault, pwm pair and dac sync inputs
// Operation
// - reserved bits written zero, read back zero
// - bit 13 picks fault-two pin or comparator B
// - bit 11 picks fault pin or comparator A
// - bits 8-6 pick pair 4/5 source
// - adc 2 outside limits forces channels 4/5
// - bits 5-3 pick pair 2/3 source
// - adc 1 outside limits forces channels 2/3
// - bits 2-0 pick pair 0/1 source
// - adc 0 outside limits forces channels 0/1
// - bits 6-4 pick dac1 sync source
// - bits 2-0 pick dac0 sync source
// - selected pin needs exactly one pin routed
// - selected pin needs its peripheral enable set
// - leave fields alone while peripheral runs
module iss_source_select #(
   parameter int DATA_W = 12
) (
   input wire logic core_clk,
   input wire logic rst_n,
   iss_reg_if.dev regs,
   input wire logic fault_two_pin,
   input wire logic fault_one_pin,
   input wire logic pair01_external_source,
   input wire logic pair23_external_source,
   input wire logic comparator_a_out,
   input wire logic comparator_b_out,
   input wire logic timer_a_ch0,
   input wire logic timer_a_ch1,
   input wire logic timer_a_ch2,
   input wire logic timer_a_ch3,
   input wire logic interval_timer_0,
   input wire logic interval_timer_1,
   input wire logic interval_timer_2,
   input wire logic pwm_reload_sync,
   input wire logic [DATA_W-1:0] adc_result_0,
   input wire logic [DATA_W-1:0] adc_result_1,
   input wire logic [DATA_W-1:0] adc_result_2,
   input wire logic [DATA_W-1:0] high_limit_0,
   input wire logic [DATA_W-1:0] high_limit_1,
   input wire logic [DATA_W-1:0] high_limit_2,
   input wire logic [DATA_W-1:0] low_limit_0,
   input wire logic [DATA_W-1:0] low_limit_1,
   input wire logic [DATA_W-1:0] low_limit_2,
   output logic pwm_fault_input_one,
   output logic pwm_fault_input_two,
   output logic pwm_ch0_src,
   output logic pwm_ch1_src,
   output logic pwm_ch2_src,
   output logic pwm_ch3_src,
   output logic pwm_ch4_src,
   output logic pwm_ch5_src,
   output logic dac0_sync,
   output logic dac1_sync
);

   localparam int PIN_N = 4;

   logic [15:0] pwm_src_q;
   logic [15:0] dac_sync_q;
   logic ack_q;
   logic [15:0] rdata_q;
   logic [PIN_N-1:0] pin_meta_q;
   logic [PIN_N-1:0] pin_sync_q;
   logic fault_one_q;
   logic fault_two_q;
   logic dac0_q;
   logic dac1_q;
   logic dac0_d;
   logic dac1_d;
   logic [2:0] pair45_source_sel;
   logic [2:0] pair23_source_sel;
   logic [2:0] pair01_source_sel;
   logic [2:0] dac1_sync_source_sel;
   logic [2:0] dac0_sync_source_sel;
   logic fault_two_source_sel;
   logic fault_one_source_sel;
   logic wr_pwm;
   logic wr_dac;

   // field views of the stored registers
   assign fault_two_source_sel = pwm_src_q[iss_pkg::ISS_FAULT_TWO_BIT];
   assign fault_one_source_sel = pwm_src_q[iss_pkg::ISS_FAULT_ONE_BIT];
   assign pair45_source_sel = pwm_src_q[iss_pkg::ISS_PAIR45_LSB +: iss_pkg::ISS_SEL_W];
   assign pair23_source_sel = pwm_src_q[iss_pkg::ISS_PAIR23_LSB +: iss_pkg::ISS_SEL_W];
   assign pair01_source_sel = pwm_src_q[iss_pkg::ISS_PAIR01_LSB +: iss_pkg::ISS_SEL_W];
   assign dac1_sync_source_sel = dac_sync_q[iss_pkg::ISS_DAC1_LSB +: iss_pkg::ISS_SEL_W];
   assign dac0_sync_source_sel = dac_sync_q[iss_pkg::ISS_DAC0_LSB +: iss_pkg::ISS_SEL_W];

   // write decode on the register port
   assign wr_pwm = regs.req && regs.wr && (regs.addr == iss_pkg::ISS_PWM_SRC_OFS);
   assign wr_dac = regs.req && regs.wr && (regs.addr == iss_pkg::ISS_DAC_SYNC_OFS);

   // select registers; reserved bits are never stored so they always read zero
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwm_src_q <= iss_pkg::ISS_PWM_SRC_RST;
         dac_sync_q <= iss_pkg::ISS_DAC_SYNC_RST;
      end else begin
         if (wr_pwm) begin
            pwm_src_q <= regs.wdata & iss_pkg::ISS_PWM_SRC_MASK;
         end
         if (wr_dac) begin
            dac_sync_q <= regs.wdata & iss_pkg::ISS_DAC_SYNC_MASK;
         end
      end
   end

   // every request is answered one cycle later; unmapped reads give zero
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         ack_q <= regs.req;
         if (regs.req && !regs.wr) begin
            case (regs.addr)
               iss_pkg::ISS_PWM_SRC_OFS: rdata_q <= pwm_src_q;
               iss_pkg::ISS_DAC_SYNC_OFS: rdata_q <= dac_sync_q;
               default: rdata_q <= 16'h0000;
            endcase
         end
      end
   end

   assign regs.ack = ack_q;
   assign regs.rdata = rdata_q;

   // pins come from outside the clock domain: two flops before any use
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end else begin
         pin_meta_q <= {pair23_external_source, pair01_external_source, fault_one_pin, fault_two_pin};
         pin_sync_q <= pin_meta_q;
      end
   end

   // fault sources; the pin choice relies on software routing one pin with its peripheral enable set
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_two_q <= 1'b0;
         fault_one_q <= 1'b0;
      end else begin
         fault_two_q <= fault_two_source_sel ? comparator_b_out : pin_sync_q[0];
         fault_one_q <= fault_one_source_sel ? comparator_a_out : pin_sync_q[1];
      end
   end

   // dac sync choice; one function serves both fields since the code sets match
   function automatic logic sync_pick(input logic [2:0] sel, input logic p0, input logic p1, input logic p2,
                                      input logic pwm, input logic ta0, input logic ta1);
      logic pick;
      pick = 1'b0;
      case (sel)
         iss_pkg::ISS_SYNC_INTERVAL_TIMER_0: pick = p0;
         iss_pkg::ISS_SYNC_INTERVAL_TIMER_1: pick = p1;
         iss_pkg::ISS_SYNC_INTERVAL_TIMER_2: pick = p2;
         iss_pkg::ISS_SYNC_PWM: pick = pwm;
         iss_pkg::ISS_SYNC_TA0: pick = ta0;
         iss_pkg::ISS_SYNC_TA1: pick = ta1;
         default: pick = 1'b0;
      endcase
      return pick;
   endfunction : sync_pick

   assign dac1_d = sync_pick(dac1_sync_source_sel, interval_timer_0, interval_timer_1, interval_timer_2,
                             pwm_reload_sync, timer_a_ch0, timer_a_ch1);
   assign dac0_d = sync_pick(dac0_sync_source_sel, interval_timer_0, interval_timer_1, interval_timer_2,
                             pwm_reload_sync, timer_a_ch0, timer_a_ch1);

   // registered dac sync outputs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dac0_q <= 1'b0;
         dac1_q <= 1'b0;
      end else begin
         dac0_q <= dac0_d;
         dac1_q <= dac1_d;
      end
   end

   // pair 0/1: external pin, timer channel 0
   iss_pair_mux #(
      .HAS_EXT(1'b1),
      .DATA_W(DATA_W)
   ) u_pair01 (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .sel(pair01_source_sel),
      .ext_src(pin_sync_q[2]),
      .timer_src(timer_a_ch0),
      .cmp_a(comparator_a_out),
      .cmp_b(comparator_b_out),
      .adc_result(adc_result_0),
      .high_limit(high_limit_0),
      .low_limit(low_limit_0),
      .even_q(pwm_ch0_src),
      .odd_q(pwm_ch1_src)
   );

   // pair 2/3: external pin, timer channel 2
   iss_pair_mux #(
      .HAS_EXT(1'b1),
      .DATA_W(DATA_W)
   ) u_pair23 (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .sel(pair23_source_sel),
      .ext_src(pin_sync_q[3]),
      .timer_src(timer_a_ch2),
      .cmp_a(comparator_a_out),
      .cmp_b(comparator_b_out),
      .adc_result(adc_result_1),
      .high_limit(high_limit_1),
      .low_limit(low_limit_1),
      .even_q(pwm_ch2_src),
      .odd_q(pwm_ch3_src)
   );

   // pair 4/5 has no pin, so code zero is reserved and drives low
   iss_pair_mux #(
      .HAS_EXT(1'b0),
      .DATA_W(DATA_W)
   ) u_pair45 (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .sel(pair45_source_sel),
      .ext_src(1'b0),
      .timer_src(timer_a_ch3),
      .cmp_a(comparator_a_out),
      .cmp_b(comparator_b_out),
      .adc_result(adc_result_2),
      .high_limit(high_limit_2),
      .low_limit(low_limit_2),
      .even_q(pwm_ch4_src),
      .odd_q(pwm_ch5_src)
   );

   assign pwm_fault_input_two = fault_two_q;
   assign pwm_fault_input_one = fault_one_q;
   assign dac0_sync = dac0_q;
   assign dac1_sync = dac1_q;

endmodule : iss_source_select

// File: rtl/iss_pkg.sv
// shared constants for the peripheral input source select block and its controller
package iss_pkg;

   // device register map, word offsets on the device's own register port
   localparam int ISS_ADDR_W = 8;
   localparam int ISS_DATA_W = 16;
   localparam logic [7:0] ISS_PWM_SRC_OFS = 8'h18;
   localparam logic [7:0] ISS_DAC_SYNC_OFS = 8'h19;
   localparam logic [15:0] ISS_PWM_SRC_RST = 16'h0000;
   localparam logic [15:0] ISS_DAC_SYNC_RST = 16'h0000;
   // implemented bits; everything else is reserved and reads zero
   localparam logic [15:0] ISS_PWM_SRC_MASK = 16'h29FF;
   localparam logic [15:0] ISS_DAC_SYNC_MASK = 16'h0077;

   // field positions in the pwm source register
   localparam int ISS_FAULT_TWO_BIT = 13;
   localparam int ISS_FAULT_ONE_BIT = 11;
   localparam int ISS_PAIR45_LSB = 6;
   localparam int ISS_PAIR23_LSB = 3;
   localparam int ISS_PAIR01_LSB = 0;
   localparam int ISS_SEL_W = 3;
   // field positions in the dac sync register
   localparam int ISS_DAC1_LSB = 4;
   localparam int ISS_DAC0_LSB = 0;

   // pair source codes
   localparam logic [2:0] ISS_PAIR_EXT = 3'h0;
   localparam logic [2:0] ISS_PAIR_TIMER = 3'h1;
   localparam logic [2:0] ISS_PAIR_ADC = 3'h2;
   localparam logic [2:0] ISS_PAIR_CMPA = 3'h3;
   localparam logic [2:0] ISS_PAIR_CMPB = 3'h4;

   // dac sync source codes
   localparam logic [2:0] ISS_SYNC_INTERVAL_TIMER_0 = 3'h0;
   localparam logic [2:0] ISS_SYNC_INTERVAL_TIMER_1 = 3'h1;
   localparam logic [2:0] ISS_SYNC_INTERVAL_TIMER_2 = 3'h2;
   localparam logic [2:0] ISS_SYNC_PWM = 3'h3;
   localparam logic [2:0] ISS_SYNC_TA0 = 3'h4;
   localparam logic [2:0] ISS_SYNC_TA1 = 3'h5;

   // controller register map, AXI4-Lite byte offsets
   localparam int ISS_AXI_ADDR_W = 8;
   localparam logic [7:0] ISS_CTL_TARGET_OFS = 8'h00;
   localparam logic [7:0] ISS_CTL_WRITE_OFS = 8'h04;
   localparam logic [7:0] ISS_CTL_READ_OFS = 8'h08;
   localparam logic [7:0] ISS_CTL_RDATA_OFS = 8'h0C;
   localparam logic [7:0] ISS_CTL_STATUS_OFS = 8'h10;
   localparam int ISS_STAT_BUSY_BIT = 0;
   localparam int ISS_STAT_DONE_BIT = 1;
   localparam logic [1:0] ISS_RESP_OKAY = 2'h0;
   localparam logic [1:0] ISS_RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {
      ISS_CTL_IDLE,
      ISS_CTL_WAIT
   } iss_ctl_state_t;

endpackage : iss_pkg

// File: rtl/iss_reg_if.sv
// register port between the source select device and its controller
interface iss_reg_if;
   logic req;
   logic wr;
   logic [7:0] addr;
   logic [15:0] wdata;
   logic ack;
   logic [15:0] rdata;

   modport dev (
      input req,
      input wr,
      input addr,
      input wdata,
      output ack,
      output rdata
   );

   modport ctl (
      output req,
      output wr,
      output addr,
      output wdata,
      input ack,
      input rdata
   );
endinterface : iss_reg_if

// File: rtl/iss_pair_mux.sv
// one pwm pair source multiplexer with registered complementary outputs
module iss_pair_mux #(
   parameter bit HAS_EXT = 1'b1,
   parameter int DATA_W = 12
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [2:0] sel,
   input wire logic ext_src,
   input wire logic timer_src,
   input wire logic cmp_a,
   input wire logic cmp_b,
   input wire logic [DATA_W-1:0] adc_result,
   input wire logic [DATA_W-1:0] high_limit,
   input wire logic [DATA_W-1:0] low_limit,
   output logic even_q,
   output logic odd_q
);

   logic even_d;
   logic odd_d;

   // single sources drive the pair complementary; adc holds between limits
   always_comb begin
      even_d = even_q;
      odd_d = odd_q;
      case (sel)
         iss_pkg::ISS_PAIR_EXT: begin
            even_d = HAS_EXT ? ext_src : 1'b0;
            odd_d = HAS_EXT ? ~ext_src : 1'b0;
         end
         iss_pkg::ISS_PAIR_TIMER: begin
            even_d = timer_src;
            odd_d = ~timer_src;
         end
         iss_pkg::ISS_PAIR_ADC: begin
            if (adc_result > high_limit) begin
               even_d = 1'b0;
               odd_d = 1'b1;
            end else if (adc_result < low_limit) begin
               even_d = 1'b1;
               odd_d = 1'b0;
            end
         end
         iss_pkg::ISS_PAIR_CMPA: begin
            even_d = cmp_a;
            odd_d = ~cmp_a;
         end
         iss_pkg::ISS_PAIR_CMPB: begin
            even_d = cmp_b;
            odd_d = ~cmp_b;
         end
         default: begin
            even_d = 1'b0;
            odd_d = 1'b0;
         end
      endcase
   end

   // outputs follow the field one cycle after it is stored
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         even_q <= 1'b0;
         odd_q <= 1'b0;
      end else begin
         even_q <= even_d;
         odd_q <= odd_d;
      end
   end

endmodule : iss_pair_mux

// File: rtl/iss_controller.sv
// controller: AXI4-Lite slave that forwards register reads and writes to the source select device
module iss_controller (
   input wire logic core_clk,
   input wire logic rst_n,
   iss_reg_if.ctl regs,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   logic awready_q;
   logic wready_q;
   logic aw_have_q;
   logic w_have_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [7:0] target_q;
   logic [15:0] dev_rdata_q;
   logic done_q;
   logic req_q;
   logic wr_q;
   logic [15:0] out_wdata_q;
   iss_pkg::iss_ctl_state_t state_q;
   logic exec;
   logic hit;
   logic launch_wr;
   logic launch_rd;
   logic busy;

   assign exec = aw_have_q && w_have_q && !bvalid_q;
   assign hit = (awaddr_q == iss_pkg::ISS_CTL_TARGET_OFS) || (awaddr_q == iss_pkg::ISS_CTL_WRITE_OFS) ||
                (awaddr_q == iss_pkg::ISS_CTL_READ_OFS);
   assign busy = (state_q == iss_pkg::ISS_CTL_WAIT);
   // a launch while a transfer is outstanding is dropped
   assign launch_wr = exec && (awaddr_q == iss_pkg::ISS_CTL_WRITE_OFS) && !busy;
   assign launch_rd = exec && (awaddr_q == iss_pkg::ISS_CTL_READ_OFS) && !busy;

   // address and data channels are taken independently, each held until the response
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         awready_q <= 1'b0;
         aw_have_q <= 1'b0;
         awaddr_q <= 8'h00;
      end else if (s_axi_awvalid && awready_q) begin
         awready_q <= 1'b0;
         aw_have_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (exec) begin
         aw_have_q <= 1'b0;
      end else if (!aw_have_q && !bvalid_q) begin
         awready_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wready_q <= 1'b0;
         w_have_q <= 1'b0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else if (s_axi_wvalid && wready_q) begin
         wready_q <= 1'b0;
         w_have_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (exec) begin
         w_have_q <= 1'b0;
      end else if (!w_have_q && !bvalid_q) begin
         wready_q <= 1'b1;
      end
   end

   // write response one cycle after both halves are present
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_q <= 1'b0;
         bresp_q <= iss_pkg::ISS_RESP_OKAY;
      end else if (exec) begin
         bvalid_q <= 1'b1;
         bresp_q <= hit ? iss_pkg::ISS_RESP_OKAY : iss_pkg::ISS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // target address, low byte lane only
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         target_q <= 8'h00;
      end else if (exec && (awaddr_q == iss_pkg::ISS_CTL_TARGET_OFS) && wstrb_q[0]) begin
         target_q <= wdata_q[7:0];
      end
   end

   // device port sequencing: one request pulse, then wait for the answer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= iss_pkg::ISS_CTL_IDLE;
         req_q <= 1'b0;
         wr_q <= 1'b0;
         out_wdata_q <= 16'h0000;
         dev_rdata_q <= 16'h0000;
         done_q <= 1'b0;
      end else begin
         req_q <= 1'b0;
         case (state_q)
            iss_pkg::ISS_CTL_IDLE: begin
               if (launch_wr || launch_rd) begin
                  req_q <= 1'b1;
                  wr_q <= launch_wr;
                  out_wdata_q <= wdata_q[15:0]; // software keeps reserved bits zero
                  done_q <= 1'b0;
                  state_q <= iss_pkg::ISS_CTL_WAIT;
               end
            end
            iss_pkg::ISS_CTL_WAIT: begin
               if (regs.ack) begin
                  if (!wr_q) begin
                     dev_rdata_q <= regs.rdata;
                  end
                  done_q <= 1'b1;
                  state_q <= iss_pkg::ISS_CTL_IDLE;
               end
            end
            default: state_q <= iss_pkg::ISS_CTL_IDLE;
         endcase
      end
   end

   assign regs.req = req_q;
   assign regs.wr = wr_q;
   assign regs.addr = target_q;
   assign regs.wdata = out_wdata_q;

   // read channel: data one cycle after the address is taken
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= iss_pkg::ISS_RESP_OKAY;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= iss_pkg::ISS_RESP_OKAY;
         case (s_axi_araddr)
            iss_pkg::ISS_CTL_TARGET_OFS: rdata_q <= {24'h000000, target_q};
            iss_pkg::ISS_CTL_WRITE_OFS: rdata_q <= {16'h0000, out_wdata_q};
            iss_pkg::ISS_CTL_READ_OFS: rdata_q <= 32'h00000000;
            iss_pkg::ISS_CTL_RDATA_OFS: rdata_q <= {16'h0000, dev_rdata_q};
            iss_pkg::ISS_CTL_STATUS_OFS: rdata_q <= {30'h0000000, done_q, busy};
            default: begin
               rdata_q <= 32'h00000000;
               rresp_q <= iss_pkg::ISS_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_q) begin
         if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end else begin
         arready_q <= 1'b1;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

endmodule : iss_controller

// File: testbench/iss_reg_properties.sv
// interface properties of the source select register port
module iss_reg_properties (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic req,
   input wire logic wr,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic ack,
   input wire logic [15:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic [15:0] pwm_q;
   // shadow of the pwm word as the device must keep it; reserved bits dropped
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) pwm_q <= 16'h0000;
      else if (req && wr && addr == 8'h18) pwm_q <= wdata & 16'h29FF;
   end
   property p_ack_next; req |=> ack; endproperty
   a_ack_next: assert property (p_ack_next) else $error("no answer after request");
   property p_ack_cause; ack |-> $past(req); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
   property p_req_pulse; req |=> !req; endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("request longer than one cycle");
   property p_pwm_rsv; req && !wr && addr == 8'h18 |=> (rdata & 16'hD600) == 16'h0000; endproperty
   a_pwm_rsv: assert property (p_pwm_rsv) else $error("pwm reserved bits read nonzero");
   property p_dac_rsv; req && !wr && addr == 8'h19 |=> (rdata & 16'hFF88) == 16'h0000; endproperty
   a_dac_rsv: assert property (p_dac_rsv) else $error("dac reserved bits read nonzero");
   property p_unmapped; req && !wr && addr != 8'h18 && addr != 8'h19 |=> rdata == 16'h0000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
   property p_hold; !(req && !wr) |=> $stable(rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved without read");
   property p_readback; req && !wr && addr == 8'h18 |=> rdata == pwm_q; endproperty
   a_readback: assert property (p_readback) else $error("pwm word read back wrong");
   c_write: cover property (req && wr && addr == 8'h18);
   c_dac_read: cover property (req && !wr && addr == 8'h19);
   c_unmapped: cover property (req && !wr && addr == 8'h20);
endmodule : iss_reg_properties

// File: testbench/tb.sv
// self-checking bench for the source select device and its controller
module tb;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_fail++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, bres;
   logic [31:0] rdata;
   logic [13:0] ip = 14'h0000;
   logic [11:0] res0 = 12'h000, res1 = 12'h000, res2 = 12'h000, hl = 12'h800, ll = 12'h400;
   wire logic [9:0] ov;
   int n_fail = 0, checks = 0;
   int m[6] = '{10, 11, 12, 13, 6, 7};
   logic [13:0] pat[4] = '{14'h1A6D, 14'h25B2, 14'h3C35, 14'h03CA};
   iss_reg_if link ();
   iss_controller u_iss_controller (.core_clk, .rst_n, .regs(link.ctl), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
   iss_source_select u_iss_source_select (.core_clk, .rst_n, .regs(link.dev), .fault_two_pin(ip[0]),
      .fault_one_pin(ip[1]), .pair01_external_source(ip[2]), .pair23_external_source(ip[3]),
      .comparator_a_out(ip[4]), .comparator_b_out(ip[5]), .timer_a_ch0(ip[6]), .timer_a_ch1(ip[7]),
      .timer_a_ch2(ip[8]), .timer_a_ch3(ip[9]), .interval_timer_0(ip[10]), .interval_timer_1(ip[11]),
      .interval_timer_2(ip[12]), .pwm_reload_sync(ip[13]), .adc_result_0(res0), .adc_result_1(res1),
      .adc_result_2(res2), .high_limit_0(hl), .high_limit_1(hl), .high_limit_2(hl), .low_limit_0(ll),
      .low_limit_1(ll), .low_limit_2(ll), .pwm_ch0_src(ov[0]), .pwm_ch1_src(ov[1]), .pwm_ch2_src(ov[2]),
      .pwm_ch3_src(ov[3]), .pwm_ch4_src(ov[4]), .pwm_ch5_src(ov[5]), .pwm_fault_input_one(ov[6]),
      .pwm_fault_input_two(ov[7]), .dac0_sync(ov[8]), .dac1_sync(ov[9]));
   iss_reg_properties u_props (.core_clk, .rst_n, .req(link.req), .wr(link.wr), .addr(link.addr),
      .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
   // expected {odd, even} of one pair; adc results sit below the low limit in the code sweep
   function automatic logic [1:0] pexp(input logic [2:0] c, input int p, input logic [13:0] v);
      logic s;
      case (c)
         3'h0: if (p == 2) return 2'b00; else s = v[2 + p];
         3'h1: s = v[p == 0 ? 6 : p == 1 ? 8 : 9];
         3'h2: return 2'b01;
         3'h3: s = v[4];
         3'h4: s = v[5];
         default: return 2'b00;
      endcase
      return {~s, s};
   endfunction : pexp
   function automatic logic [9:0] exp_out(input logic [2:0] c, input logic [13:0] v);
      logic [2:0] d1;
      d1 = c ^ 3'h1;
      return {d1 < 6 ? v[m[d1]] : 1'b0, c < 6 ? v[m[c]] : 1'b0, c[1] ? v[5] : v[0], c[0] ? v[4] : v[1],
         pexp(c, 2, v), pexp(c, 1, v), pexp(c, 0, v)};
   endfunction : exp_out
   // master holds each valid until its own ready; responses are always accepted
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bres = bresp;
   endtask : axw
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
   endtask : axr
   // one device access: set target, launch (0x04 write, 0x08 read), wait done, fetch read data
   task automatic dop(input logic [7:0] a, input logic [7:0] go, input logic [15:0] d, output logic [15:0] q);
      logic [31:0] v;
      logic [1:0] r;
      axw(8'h00, {24'h000000, a});
      axw(go, {16'h0000, d});
      axr(8'h10, v, r);
      `CHK("status busy", 2'h1, v[1:0])
      while (!v[1]) axr(8'h10, v, r);
      axr(8'h0C, v, r);
      q = v[15:0];
   endtask : dop
   task automatic summarize();
      if (n_fail == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      summarize();
   end
   initial begin
      logic [15:0] q;
      logic [31:0] v;
      logic [1:0] r;
      logic [2:0] c;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      `CHK("reset outputs", 10'h00A, ov)
      dop(8'h18, 8'h08, 16'h0000, q);
      `CHK("pwm reset", 16'h0000, q)
      dop(8'h19, 8'h08, 16'h0000, q);
      `CHK("dac reset", 16'h0000, q)
      dop(8'h18, 8'h04, 16'h29FF, q);
      `CHK("bus write okay", 2'h0, bres)
      dop(8'h18, 8'h08, 16'h0000, q);
      `CHK("pwm reserved", 16'h29FF, q)
      dop(8'h19, 8'h04, 16'h0077, q);
      dop(8'h19, 8'h08, 16'h0000, q);
      `CHK("dac reserved", 16'h0077, q)
      `CHK("dac reserved code", 2'h0, ov[9:8])
      dop(8'h20, 8'h08, 16'h0000, q);
      `CHK("device unmapped", 16'h0000, q)
      axr(8'h40, v, r);
      `CHK("bus unmapped", 2'h2, r)
      axw(8'h40, 32'h00000000);
      `CHK("bus write unmapped", 2'h2, bres)
      // sweep every code of every field against four input patterns
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         dop(8'h18, 8'h04, {2'b00, c[1], 1'b0, c[0], 2'b00, c, c, c}, q);
         dop(8'h19, 8'h04, {9'h00, c ^ 3'h1, 1'b0, c}, q);
         for (int k = 0; k < 4; k++) begin
            ip <= pat[k];
            repeat (4) @(posedge core_clk);
            `CHK("mux outputs", exp_out(c, pat[k]), ov)
         end
      end
      dop(8'h18, 8'h04, 16'h0092, q);
      res0 <= 12'h801;
      res1 <= 12'h3FF;
      res2 <= 12'h801;
      repeat (2) @(posedge core_clk);
      `CHK("adc outside", 6'h26, ov[5:0])
      res0 <= 12'h800;
      res1 <= 12'h801;
      res2 <= 12'h3FF;
      repeat (2) @(posedge core_clk);
      `CHK("adc edge", 6'h1A, ov[5:0])
      summarize();
   end
endmodule : tb
